// ---- design/bmsk_map.svh ----
// bmsk_map.svh: offsets, field positions, reset values and counts for the boot loader
// assumes: included by bare name from the packer and top design modules
`ifndef BMSK_MAP_SVH
`define BMSK_MAP_SVH

`define BMSK_KERNEL_WORDS      9'h100
`define BMSK_EPROM_BYTES       12'h600
`define BMSK_BYTES_PER_WORD    3'h6
`define BMSK_WAIT_STATES       3'h6
`define BMSK_READ_CYCLES       3'h7
`define BMSK_EPROM_BASE_VAR_A  24'h400000
`define BMSK_EPROM_BASE_VAR_B  24'h000000
`define BMSK_EPROM_BASE_VAR_C  24'h800000
`define BMSK_BLOCK0_VAR_A      20'h20000
`define BMSK_BLOCK0_VAR_B      20'h08000
`define BMSK_BLOCK0_VAR_C      20'h40000
`define BMSK_RSTVEC_OFFSET     20'h00004
`define BMSK_NOBOOT_ADDR       20'h20004
`define BMSK_DMA_CH_SMALL      4'h8
`define BMSK_DMA_CH_A          4'h6
`define BMSK_DMA_CH_C_EXT      4'ha
`define BMSK_DMA_CH_C_LINK     4'h8
`define BMSK_DMA_CTL_SMALL     4'h0
`define BMSK_ADDR_CTRL         2'h0
`define BMSK_ADDR_STATUS       2'h1
`define BMSK_ADDR_START        2'h2
`define BMSK_ADDR_COUNT        2'h3
`define BMSK_CTRL_BSO_BIT      0
`define BMSK_CTRL_KDONE_BIT    1
`define BMSK_CTRL_BUSM_BIT     2
`define BMSK_CTRL_TRI_BIT      3
`define BMSK_CTRL_RESET        4'h5

`endif

// ---- design/bmsk_pkg.sv ----
// bmsk_pkg: types shared by the boot mode loader modules
// assumes: bmsk_map.svh is on the include path
`default_nettype none
package bmsk_pkg;
  typedef enum logic [2:0] {
    BMSK_MODE_NOBOOT = 3'h0,
    BMSK_MODE_HOST   = 3'h1,
    BMSK_MODE_LINK   = 3'h2,
    BMSK_MODE_EPROM  = 3'h3,
    BMSK_MODE_RSVD   = 3'h4
  } bmsk_mode_type;

  typedef enum logic [1:0] {
    BMSK_VAR_A     = 2'h0,
    BMSK_VAR_SMALL = 2'h1,
    BMSK_VAR_C     = 2'h2
  } bmsk_variant_type;

  typedef enum logic [5:0] {
    BMSK_ST_IDLE  = 6'h01,
    BMSK_ST_READ  = 6'h02,
    BMSK_ST_WORD  = 6'h04,
    BMSK_ST_KERN  = 6'h08,
    BMSK_ST_RUN   = 6'h10,
    BMSK_ST_HALT  = 6'h20
  } bmsk_state_type;
endpackage : bmsk_pkg
`default_nettype wire

// ---- design/bmsk_pack_if.sv ----
// bmsk_pack_if: byte-to-instruction packer handshake between the loader and its packer
// assumes: one clock domain, driven by bmsk_top
`default_nettype none
interface bmsk_pack_if;
  logic        clear;
  logic        byte_valid;
  logic [7:0]  byte_data;
  logic        word_valid;
  logic [47:0] word_data;
  modport loader (output clear, output byte_valid, output byte_data, input word_valid, input word_data);
  modport packer (input clear, input byte_valid, input byte_data, output word_valid, output word_data);
endinterface : bmsk_pack_if
`default_nettype wire

// ---- design/bmsk_packer.sv ----
// bmsk_packer: packs six boot bytes into one 48-bit instruction, low byte first
// assumes: byte_valid pulses one cycle per byte; clear restarts a word
`default_nettype none
`include "bmsk_map.svh"
module bmsk_packer
  import bmsk_pkg::*;
(
  // clocking
  input  wire logic REF_CLK,
  input  wire logic ARST_N,
  input  wire logic CLK_EN,
  // loader side
  bmsk_pack_if.packer pk
);
  logic [47:0] shift_reg;
  logic [2:0]  count_reg;
  logic        word_valid_reg;

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      shift_reg      <= 48'h0;
      count_reg      <= 3'h0;
      word_valid_reg <= 1'b0;
    end else if (CLK_EN) begin
      word_valid_reg <= 1'b0;
      if (pk.clear) begin
        count_reg <= 3'h0;
      end else if (pk.byte_valid) begin
        // low byte arrives first, so new bytes enter at the top
        shift_reg <= {pk.byte_data, shift_reg[47:8]};
        if (count_reg == `BMSK_BYTES_PER_WORD - 3'h1) begin
          count_reg      <= 3'h0;
          word_valid_reg <= 1'b1;
        end else begin
          count_reg <= count_reg + 3'h1;
        end
      end
    end
  end

  assign pk.word_valid = word_valid_reg;
  assign pk.word_data  = shift_reg;
endmodule : bmsk_packer
`default_nettype wire

// ---- design/bmsk_top.sv ----
// bmsk_top: power-up boot mode select and boot kernel load
// assumes: straps are static, synchronous to REF_CLK; EPROM answers within the fixed read window
//
// Contract
// - load boot kernel after every reset; code loads only in EPROM mode, host and link skip the load
// - DMA copies 256 words of 48 bits
// - boot DMA channel chosen per variant
// - loaded kernel then runs the application load
// - kernel area overwritten by application start
// - start at block 0 of variant
// - reset vector word never executed during boot
// - EPROM strap high selects byte EPROM boot
// - link strap picks link or host boot
// - select pin output in EPROM, else input
// - only bus master drives select output
// - three pins decode boot mode table
// - select output can be three-stated
// - single strap: pin chooses noboot or host
// - single strap EPROM uses low data byte
// - single strap host defaults to 8 bits
// - single strap noboot runs from fixed address
// - bytes packed low first into instructions
// - each EPROM read is seven cycles
// - both counts decrement; stop at zero
// - clearing boot-select bit releases select pin; code keeps the pin driven, deasserted high
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`default_nettype none
`include "bmsk_map.svh"
module bmsk_top
  import bmsk_pkg::*;
#(
  parameter bmsk_variant_type VARIANT = BMSK_VAR_A
)(
  // clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        ARST_N,
  input  wire logic        CLK_EN,
  // boot straps
  input  wire logic        EPROM_BOOT_STRAP,
  input  wire logic        LINK_BOOT_STRAP,
  input  wire logic        SINGLE_EPROM_SELECT_STRAP,
  // boot memory select pin, active low
  input  wire logic        BOOT_MEMORY_SELECT_N_I,
  output logic             BOOT_MEMORY_SELECT_N_O,
  output logic             BOOT_MEMORY_SELECT_N_OE,
  // external EPROM port
  output logic [23:0]      EXT_ADDR,
  output logic             EXT_READ_N,
  input  wire logic [7:0]  EXT_DATA_LOW,
  // internal memory write port
  output logic             MEM_WE,
  output logic [19:0]      MEM_ADDR,
  output logic [47:0]      MEM_WDATA,
  // core start
  output logic             CORE_START,
  output logic [19:0]      CORE_PC,
  // status
  output logic [2:0]       BOOT_MODE,
  output logic             MODE_INVALID,
  output logic [3:0]       DMA_CHANNEL,
  output logic             HOST_BUS_8BIT,
  // register port
  input  wire logic [1:0]  REG_ADDR,
  input  wire logic [15:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic [15:0]      REG_RDATA
);
  bmsk_pack_if pk ();

  bmsk_packer u_packer (
    .REF_CLK (REF_CLK),
    .ARST_N  (ARST_N),
    .CLK_EN  (CLK_EN),
    .pk      (pk)
  );

  bmsk_state_type state_reg;
  bmsk_state_type state_next;
  bmsk_mode_type  mode_reg;
  logic           sampled_reg;
  logic [3:0]     ctrl_reg;
  logic [8:0]     int_count_reg;
  logic [11:0]    ext_count_reg;
  logic [2:0]     wait_reg;
  logic [19:0]    block0;
  logic [23:0]    eprom_base;
  logic           is_eprom;
  logic           dma_done;
  bmsk_mode_type  mode_next;

  // variant-fixed block 0 and EPROM base addresses
  always_comb begin
    case (VARIANT)
      BMSK_VAR_SMALL: begin
        block0     = `BMSK_BLOCK0_VAR_B;
        eprom_base = `BMSK_EPROM_BASE_VAR_B;
      end
      BMSK_VAR_C: begin
        block0     = `BMSK_BLOCK0_VAR_C;
        eprom_base = `BMSK_EPROM_BASE_VAR_C;
      end
      default: begin
        block0     = `BMSK_BLOCK0_VAR_A;
        eprom_base = `BMSK_EPROM_BASE_VAR_A;
      end
    endcase
  end

  // strap decode; reserved codes yield no DMA
  always_comb begin
    mode_next = BMSK_MODE_RSVD;
    if (VARIANT == BMSK_VAR_SMALL) begin
      if (SINGLE_EPROM_SELECT_STRAP)
        mode_next = BMSK_MODE_EPROM;
      else if (BOOT_MEMORY_SELECT_N_I)
        mode_next = BMSK_MODE_HOST;
      else
        mode_next = BMSK_MODE_NOBOOT;
    end else begin
      case ({EPROM_BOOT_STRAP, LINK_BOOT_STRAP, BOOT_MEMORY_SELECT_N_I})
        3'h0:    mode_next = BMSK_MODE_NOBOOT;
        3'h1:    mode_next = BMSK_MODE_HOST;
        3'h3:    mode_next = BMSK_MODE_LINK;
        3'h4,
        3'h5:    mode_next = BMSK_MODE_EPROM;
        default: mode_next = BMSK_MODE_RSVD;
      endcase
    end
  end

  assign is_eprom = (mode_reg == BMSK_MODE_EPROM);
  assign dma_done = (int_count_reg == 9'h0) && (ext_count_reg == 12'h0);

  // one sample after release; pin is not yet driven then, so it reads as an input
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sampled_reg  <= 1'b0;
      mode_reg     <= BMSK_MODE_RSVD;
      BOOT_MODE    <= 3'h4;
      MODE_INVALID <= 1'b0;
    end else if (CLK_EN && !sampled_reg) begin
      sampled_reg  <= 1'b1;
      mode_reg     <= mode_next;
      BOOT_MODE    <= mode_next;
      MODE_INVALID <= (mode_next == BMSK_MODE_RSVD);
    end
  end

  // boot DMA channel: small part programs channel 8 through channel-0 control
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      DMA_CHANNEL   <= 4'h0;
      HOST_BUS_8BIT <= 1'b0;
    end else if (CLK_EN && !sampled_reg) begin
      HOST_BUS_8BIT <= (VARIANT == BMSK_VAR_SMALL) && (mode_next == BMSK_MODE_HOST);
      if (VARIANT == BMSK_VAR_SMALL)
        DMA_CHANNEL <= `BMSK_DMA_CH_SMALL;
      else if (VARIANT == BMSK_VAR_C)
        DMA_CHANNEL <= (mode_next == BMSK_MODE_LINK) ? `BMSK_DMA_CH_C_LINK : `BMSK_DMA_CH_C_EXT;
      else
        DMA_CHANNEL <= `BMSK_DMA_CH_A;
    end
  end

  // sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      BMSK_ST_IDLE: begin
        if (sampled_reg) begin
          if (mode_reg == BMSK_MODE_RSVD)
            state_next = BMSK_ST_HALT;
          else if (mode_reg == BMSK_MODE_NOBOOT)
            state_next = BMSK_ST_RUN;
          else if (is_eprom)
            state_next = BMSK_ST_READ;
          else
            state_next = BMSK_ST_KERN;
        end
      end
      BMSK_ST_READ: if (wait_reg == `BMSK_WAIT_STATES) state_next = BMSK_ST_WORD;
      BMSK_ST_WORD: begin
        // the last word is counted a cycle after its last byte, so hold here until both counts are zero
        if (dma_done)
          state_next = BMSK_ST_KERN;
        else if (ext_count_reg != 12'h0)
          state_next = BMSK_ST_READ;
      end
      BMSK_ST_KERN: if (!ctrl_reg[`BMSK_CTRL_BSO_BIT] && ctrl_reg[`BMSK_CTRL_KDONE_BIT]) state_next = BMSK_ST_RUN;
      BMSK_ST_RUN:  state_next = BMSK_ST_RUN;
      BMSK_ST_HALT: state_next = BMSK_ST_HALT;
      default:      state_next = BMSK_ST_HALT;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N)
      state_reg <= BMSK_ST_IDLE;
    else if (CLK_EN)
      state_reg <= state_next;
  end

  // read strobe held seven cycles: one plus six wait states
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wait_reg   <= 3'h0;
      EXT_READ_N <= 1'b1;
    end else if (CLK_EN) begin
      if (state_next == BMSK_ST_READ) begin
        EXT_READ_N <= 1'b0;
        wait_reg   <= (state_reg == BMSK_ST_READ) ? wait_reg + 3'h1 : 3'h0;
      end else begin
        EXT_READ_N <= 1'b1;
        wait_reg   <= 3'h0;
      end
    end
  end

  // byte capture at the last read cycle; counts step per transfer
  assign pk.clear      = (state_reg == BMSK_ST_IDLE);
  assign pk.byte_valid = (state_reg == BMSK_ST_READ) && (wait_reg == `BMSK_WAIT_STATES);
  assign pk.byte_data  = EXT_DATA_LOW;

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      int_count_reg <= `BMSK_KERNEL_WORDS;
      ext_count_reg <= `BMSK_EPROM_BYTES;
      EXT_ADDR      <= 24'h0;
    end else if (CLK_EN) begin
      if (state_reg == BMSK_ST_IDLE) begin
        int_count_reg <= `BMSK_KERNEL_WORDS;
        ext_count_reg <= `BMSK_EPROM_BYTES;
        EXT_ADDR      <= eprom_base;
      end else begin
        if (pk.byte_valid) begin
          ext_count_reg <= ext_count_reg - 12'h1;
          EXT_ADDR      <= EXT_ADDR + 24'h1;
        end
        if (pk.word_valid && int_count_reg != 9'h0)
          int_count_reg <= int_count_reg - 9'h1;
      end
    end
  end

  // kernel words land from block 0 upward
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      MEM_WE    <= 1'b0;
      MEM_ADDR  <= 20'h0;
      MEM_WDATA <= 48'h0;
    end else if (CLK_EN) begin
      MEM_WE <= pk.word_valid;
      if (pk.word_valid) begin
        MEM_ADDR  <= block0 + {11'h0, `BMSK_KERNEL_WORDS - int_count_reg};
        MEM_WDATA <= pk.word_data;
      end
    end
  end

  // core start: kernel at block 0 skipping reset vector, then app at block 0
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      CORE_START <= 1'b0;
      CORE_PC    <= 20'h0;
    end else if (CLK_EN) begin
      if (state_reg != BMSK_ST_KERN && state_next == BMSK_ST_KERN) begin
        CORE_START <= 1'b1;
        CORE_PC    <= block0 + `BMSK_RSTVEC_OFFSET + 20'h1;
      end else if (state_reg != BMSK_ST_RUN && state_next == BMSK_ST_RUN) begin
        CORE_START <= 1'b1;
        CORE_PC    <= (mode_reg == BMSK_MODE_NOBOOT) ?
                      ((VARIANT == BMSK_VAR_SMALL) ? `BMSK_NOBOOT_ADDR : block0) :
                      block0;
      end else begin
        CORE_START <= 1'b0;
      end
    end
  end

  // control register: boot-select override, kernel done, bus master, three-state
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N)
      ctrl_reg <= `BMSK_CTRL_RESET;
    else if (CLK_EN && REG_WR && REG_ADDR == `BMSK_ADDR_CTRL)
      ctrl_reg <= REG_WDATA[3:0];
  end

  // select pin drives only in EPROM mode, as bus master, with three-state bit clear
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      BOOT_MEMORY_SELECT_N_OE <= 1'b0;
      BOOT_MEMORY_SELECT_N_O  <= 1'b1;
    end else if (CLK_EN) begin
      BOOT_MEMORY_SELECT_N_OE <= is_eprom && sampled_reg
                                 && ctrl_reg[`BMSK_CTRL_BUSM_BIT]
                                 && !ctrl_reg[`BMSK_CTRL_TRI_BIT];
      BOOT_MEMORY_SELECT_N_O  <= !(is_eprom && ctrl_reg[`BMSK_CTRL_BSO_BIT]
                                   && state_next == BMSK_ST_READ);
    end
  end

  // read data one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N)
      REG_RDATA <= 16'h0;
    else if (CLK_EN) begin
      if (REG_RD) begin
        case (REG_ADDR)
          `BMSK_ADDR_CTRL:   REG_RDATA <= {12'h0, ctrl_reg};
          `BMSK_ADDR_STATUS: REG_RDATA <= {2'h0, DMA_CHANNEL, state_reg, MODE_INVALID, BOOT_MODE};
          `BMSK_ADDR_START:  REG_RDATA <= CORE_PC[15:0];
          `BMSK_ADDR_COUNT:  REG_RDATA <= {7'h0, int_count_reg};
          default:           REG_RDATA <= 16'h0;
        endcase
      end else begin
        REG_RDATA <= 16'h0;
      end
    end
  end
endmodule : bmsk_top
`default_nettype wire

// ---- tb/bmsk_eprom_model.sv ----
// bmsk_eprom_model: byte-wide boot EPROM hanging on the low data lines
// assumes: selected by the active-low select pin, read strobe active low
`default_nettype none
module bmsk_eprom_model (
  // clock
  input  wire logic        clk,
  // EPROM pins
  input  wire logic [23:0] addr,
  input  wire logic        read_n,
  input  wire logic        select_n,
  output logic      [7:0]  data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] data_reg = 8'h00;

  function automatic logic [7:0] rom_byte(input logic [23:0] a);
    return a[7:0] ^ {5'h00, a[10:8]} ^ 8'h3c;
  endfunction : rom_byte

  // no hold time: when not read, the lines keep changing so a stale byte cannot pass
  always @(posedge clk) begin
    if (!read_n && !select_n) data_reg <= rom_byte(addr);
    else data_reg <= ~data_reg;
  end
  assign data = data_reg;
endmodule : bmsk_eprom_model
`default_nettype wire

// ---- tb/bmsk_top_properties.sv ----
// bmsk_top_properties: port checks for the boot mode loader
// assumes: bmsk_top built for the default variant, CLK_EN held high
`default_nettype none
module bmsk_top_properties (
  // clock and reset
  input wire logic        REF_CLK,
  input wire logic        ARST_N,
  // straps and select pin
  input wire logic        EPROM_BOOT_STRAP,
  input wire logic        LINK_BOOT_STRAP,
  input wire logic        BOOT_MEMORY_SELECT_N_I,
  input wire logic        BOOT_MEMORY_SELECT_N_O,
  input wire logic        BOOT_MEMORY_SELECT_N_OE,
  // load and start
  input wire logic [23:0] EXT_ADDR,
  input wire logic        EXT_READ_N,
  input wire logic        MEM_WE,
  input wire logic        CORE_START,
  input wire logic [19:0] CORE_PC,
  // status and register port
  input wire logic [2:0]  BOOT_MODE,
  input wire logic        MODE_INVALID,
  input wire logic        REG_RD,
  input wire logic [15:0] REG_RDATA
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);
  logic [2:0] mode_exp;

  always_comb begin
    if (EPROM_BOOT_STRAP) mode_exp = LINK_BOOT_STRAP ? 3'h4 : 3'h3;
    else if (!BOOT_MEMORY_SELECT_N_I) mode_exp = LINK_BOOT_STRAP ? 3'h4 : 3'h0;
    else mode_exp = LINK_BOOT_STRAP ? 3'h2 : 3'h1;
  end

  chk_mode_decode: assert property ($past(ARST_N, 2) |->
    BOOT_MODE == mode_exp && MODE_INVALID == (mode_exp == 3'h4)) else $error("boot mode decode wrong");
  chk_reserved_quiet: assert property (MODE_INVALID |-> EXT_READ_N && !MEM_WE && !CORE_START)
    else $error("activity in reserved mode");
  chk_read_window: assert property ($fell(EXT_READ_N) |-> !EXT_READ_N [*7] ##1 EXT_READ_N)
    else $error("read strobe not seven cycles");
  chk_addr_step: assert property ($rose(EXT_READ_N) |-> EXT_ADDR == $past(EXT_ADDR) + 24'h000001)
    else $error("byte address did not step by one");
  chk_select_owner: assert property (BOOT_MEMORY_SELECT_N_OE |-> BOOT_MODE == 3'h3)
    else $error("select pin driven outside eprom mode");
  chk_select_read: assert property (BOOT_MEMORY_SELECT_N_OE && !EXT_READ_N |-> !BOOT_MEMORY_SELECT_N_O)
    else $error("eprom not selected during read");
  chk_word_pulse: assert property ($rose(MEM_WE) |=> !MEM_WE [*8])
    else $error("word write not a single pulse");
  chk_start_addr: assert property (CORE_START |-> CORE_PC == 20'h20005 || CORE_PC == 20'h20000)
    else $error("core started at wrong address");
  chk_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 16'h0000)
    else $error("read data outside read answer cycle");
endmodule : bmsk_top_properties

bind bmsk_top bmsk_top_properties bmsk_top_properties_inst (
  .REF_CLK(REF_CLK), .ARST_N(ARST_N), .EPROM_BOOT_STRAP(EPROM_BOOT_STRAP), .LINK_BOOT_STRAP(LINK_BOOT_STRAP),
  .BOOT_MEMORY_SELECT_N_I(BOOT_MEMORY_SELECT_N_I), .BOOT_MEMORY_SELECT_N_O(BOOT_MEMORY_SELECT_N_O),
  .BOOT_MEMORY_SELECT_N_OE(BOOT_MEMORY_SELECT_N_OE), .EXT_ADDR(EXT_ADDR), .EXT_READ_N(EXT_READ_N),
  .MEM_WE(MEM_WE), .CORE_START(CORE_START), .CORE_PC(CORE_PC), .BOOT_MODE(BOOT_MODE),
  .MODE_INVALID(MODE_INVALID), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA));
`default_nettype wire

// ---- tb/tb.sv ----
// tb: self-checking bench for the boot mode loader, default variant
// assumes: EPROM model on the low data lines, select pin held at its strap level when released
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_total++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, (a), (e)); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        eprom_strap = 1'b0;
  logic        link_strap = 1'b0;
  logic        pin_strap = 1'b1;
  logic [1:0]  reg_addr = 2'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        pin_lvl, sel_o, sel_oe, ext_read_n, mem_we, core_start, mode_invalid, host_8bit, prev_rd = 1'b1;
  logic [23:0] ext_addr, first_addr;
  logic [7:0]  ext_data;
  logic [19:0] mem_addr, core_pc, last_pc;
  logic [47:0] mem_wdata, exp_word;
  logic [2:0]  boot_mode;
  logic [3:0]  dma_channel;
  logic [15:0] reg_rdata, d;
  int          err_total = 0, comparisons = 0, cycles = 0, wr_cnt = 0, rd_falls = 0, starts = 0;

  // released pin floats to the pull-up or to the chosen strap level
  assign pin_lvl = sel_oe ? sel_o : pin_strap;

  bmsk_top bmsk_top_inst (
    .REF_CLK(ref_clk), .ARST_N(arst_n), .CLK_EN(1'b1), .EPROM_BOOT_STRAP(eprom_strap),
    .LINK_BOOT_STRAP(link_strap), .SINGLE_EPROM_SELECT_STRAP(1'b0), .BOOT_MEMORY_SELECT_N_I(pin_lvl),
    .BOOT_MEMORY_SELECT_N_O(sel_o), .BOOT_MEMORY_SELECT_N_OE(sel_oe), .EXT_ADDR(ext_addr),
    .EXT_READ_N(ext_read_n), .EXT_DATA_LOW(ext_data), .MEM_WE(mem_we), .MEM_ADDR(mem_addr),
    .MEM_WDATA(mem_wdata), .CORE_START(core_start), .CORE_PC(core_pc), .BOOT_MODE(boot_mode),
    .MODE_INVALID(mode_invalid), .DMA_CHANNEL(dma_channel), .HOST_BUS_8BIT(host_8bit), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata));

  bmsk_eprom_model bmsk_eprom_model_inst (
    .clk(ref_clk), .addr(ext_addr), .read_n(ext_read_n), .select_n(pin_lvl), .data(ext_data));

  function automatic logic [7:0] rom_byte(input logic [23:0] a);
    return a[7:0] ^ {5'h00, a[10:8]} ^ 8'h3c;
  endfunction : rom_byte

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish

  // straps only move while reset is held, as a hardwired board would
  task automatic boot(input logic [2:0] code);
    @(posedge ref_clk);
    arst_n <= 1'b0;
    eprom_strap <= code[2];
    link_strap <= code[1];
    pin_strap <= code[0];
    repeat (2) @(posedge ref_clk);
    wr_cnt = 0;
    rd_falls = 0;
    starts = 0;
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask : boot

  task automatic bus_write(input logic [1:0] a, input logic [15:0] v);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : bus_write

  task automatic bus_read(input logic [1:0] a, output logic [15:0] v);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : bus_read

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : settle

  initial begin
    forever #50 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      err_total++;
      tally_and_finish();
    end
    if (!ext_read_n && prev_rd) begin
      if (rd_falls == 0) first_addr = ext_addr;
      rd_falls++;
    end
    prev_rd = ext_read_n;
    if (core_start) begin
      starts++;
      last_pc = core_pc;
    end
    if (mem_we) begin
      for (int b = 0; b < 6; b++) exp_word[8*b +: 8] = rom_byte(24'h400000 + 24'(6 * wr_cnt + b));
      `CHK(mem_wdata, exp_word)
      `CHK(mem_addr, 20'h20000 + 20'(wr_cnt))
      wr_cnt++;
    end
  end

  initial begin : main
    logic [2:0] codes [6];
    logic [2:0] modes [6];
    codes = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
    modes = '{3'h0, 3'h1, 3'h4, 3'h2, 3'h4, 3'h4};
    for (int k = 0; k < 6; k++) begin
      boot(codes[k]);
      `CHK(boot_mode, modes[k])
      `CHK(mode_invalid, modes[k] == 3'h4)
      if (k == 1 || k == 3) `CHK(dma_channel, 4'h6)
      `CHK(host_8bit, 1'b0)
      if (k == 0) bus_read(2'h0, d);
      if (k == 0) `CHK(d, 16'h0005)
      settle(20);
      `CHK(rd_falls, 0)
      `CHK(sel_oe, 1'b0)
      `CHK(boot_mode, modes[k])
      $display("test strap decode %0d done", k);
    end
    boot(3'h4);
    `CHK(boot_mode, 3'h3)
    `CHK(dma_channel, 4'h6)
    for (int n = 0; n < 13500 && wr_cnt < 256; n++) @(posedge ref_clk);
    settle(20);
    `CHK(wr_cnt, 256)
    `CHK(rd_falls, 1536)
    `CHK(first_addr, 24'h400000)
    `CHK(starts, 1)
    `CHK(last_pc, 20'h20005)
    bus_read(2'h3, d);
    `CHK(d, 16'h0000)
    bus_write(2'h2, 16'hffff);
    bus_read(2'h2, d);
    `CHK(d, 16'h0005)
    $display("test eprom load done");
    `CHK(sel_oe, 1'b1)
    bus_write(2'h0, 16'h000d);
    settle(2);
    `CHK(sel_oe, 1'b0)
    bus_write(2'h0, 16'h0001);
    settle(2);
    `CHK(sel_oe, 1'b0)
    bus_write(2'h0, 16'h0006);
    settle(3);
    `CHK(starts, 2)
    `CHK(last_pc, 20'h20000)
    `CHK(pin_lvl, 1'b1)
    $display("test kernel handover done");
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
